// ==== design/drt_pkg.sv ====
// Constants shared by the dual 8-bit reload timer pair.
// Assumes a 32-bit APB slave port with 12-bit byte addresses.
`default_nettype none

package drt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FIRST_COUNTER = 8'h68;
  localparam logic [7:0] IDX_SECOND_COUNTER = 8'h69;
  localparam logic [7:0] IDX_FIRST_RELOAD = 8'h6A;
  localparam logic [7:0] IDX_SECOND_RELOAD = 8'h6B;
  localparam logic [7:0] IDX_FIRST_CONTROL = 8'h6C;
  localparam logic [7:0] IDX_SECOND_CONTROL = 8'h6D;

  localparam logic [11:0] ADDR_FIRST_COUNTER = {2'b00, IDX_FIRST_COUNTER, 2'b00};
  localparam logic [11:0] ADDR_SECOND_COUNTER = {2'b00, IDX_SECOND_COUNTER, 2'b00};
  localparam logic [11:0] ADDR_FIRST_RELOAD = {2'b00, IDX_FIRST_RELOAD, 2'b00};
  localparam logic [11:0] ADDR_SECOND_RELOAD = {2'b00, IDX_SECOND_RELOAD, 2'b00};
  localparam logic [11:0] ADDR_FIRST_CONTROL = {2'b00, IDX_FIRST_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_SECOND_CONTROL = {2'b00, IDX_SECOND_CONTROL, 2'b00};

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_SEL_MSB = 2;
  localparam int CTL_RUN_BIT = 3;
  localparam int CTL_WIDE_BIT = 4;
  localparam int CTL_PWM_BIT = 5;
  localparam int CTL_OUT_BIT = 7;

  localparam logic [7:0] FIRST_CONTROL_RESET = 8'h70;
  localparam logic [7:0] SECOND_CONTROL_RESET = 8'h40;
  localparam logic [2:0] FIRST_CONTROL_ONES = 3'h7;
  localparam logic SECOND_CONTROL_ONE = 1'b1;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_TOP = 8'hFF;

  // ----------------------------------------------------------------
  // Count clock select codes and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_TB_DIV1 = 3'h0;
  localparam logic [2:0] SEL_TB_DIV2 = 3'h1;
  localparam logic [2:0] SEL_TB_DIV4 = 3'h2;
  localparam logic [2:0] SEL_TB_DIV8 = 3'h3;
  localparam logic [2:0] SEL_TB_DIV32 = 3'h4;
  localparam logic [2:0] SEL_TB_DIV256 = 3'h5;
  localparam logic [2:0] SEL_EVT_RISE = 3'h6;
  localparam logic [2:0] SEL_EVT_FALL = 3'h7;

  localparam logic [7:0] PRE_MASK_DIV2 = 8'h01;
  localparam logic [7:0] PRE_MASK_DIV4 = 8'h03;
  localparam logic [7:0] PRE_MASK_DIV8 = 8'h07;
  localparam logic [7:0] PRE_MASK_DIV32 = 8'h1F;
  localparam logic [7:0] PRE_MASK_DIV256 = 8'hFF;

endpackage

`default_nettype wire

// ==== design/drt_src_if.sv ====
// Count-source bundle between the timer core and a clock selector.
// Assumes the core drives taps and edges, the selector returns one pulse.
`default_nettype none

interface drt_src_if;
  logic [5:0] div_tick;
  logic evt_rise;
  logic evt_fall;
  logic [2:0] sel;
  logic count_pulse;

  modport select_mp (
    input div_tick,
    input evt_rise,
    input evt_fall,
    input sel,
    output count_pulse
  );

  modport core_mp (
    output div_tick,
    output evt_rise,
    output evt_fall,
    output sel,
    input count_pulse
  );
endinterface

`default_nettype wire

// ==== design/drt_event_sync.sv ====
// Event pin synchroniser with edge pulses.
// Assumes the pin is asynchronous to pclk; an edge counts once stages two and three agree.
`default_nettype none

module drt_event_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  // One-cycle glitches never reach the level, so they make no edge
  assign rise = s2_reg & s3_reg & ~level_reg;
  assign fall = ~s2_reg & ~s3_reg & level_reg;

endmodule

`default_nettype wire

// ==== design/drt_clock_select.sv ====
// Count clock selector for one timer.
// Assumes the tap and edge inputs are single-cycle pulses on pclk; sel is a level.
`default_nettype none

module drt_clock_select (
  drt_src_if.select_mp src
);

  logic [7:0] source_vec;

  assign source_vec = {src.evt_fall, src.evt_rise, src.div_tick};
  assign src.count_pulse = source_vec[src.sel];

endmodule

`default_nettype wire

// ==== design/drt_timer_pair.sv ====
// Dual 8-bit auto-reload timer pair with 16-bit chain and PWM modes.
// Assumes an APB master on pclk and a timebase pulse on the same clock.
//
// Operation
// - Each counter is 8-bit up; overflow raises its request and reloads it.
// - Writing a counter also writes its reload register.
// - Reload registers are 8-bit read/write; reset value is not required.
// - First control: bits 0-2 clock select, bit 3 run, bit 7 output level.
// - First output level bit inverts on each first overflow.
// - First control bits 4-6 ignore writes and read as one.
// - Second control bit 6 ignores writes and reads as one.
// - Clock select codes: base, /2, /4, /8, /32, /256, event rise, fall.
// - Second control bit 3 starts or halts the second counter.
// - Bit 4 chains both into 16 bits; second select and run ignored.
// - Bit 5 selects PWM; second run ignored; first run starts both.
// - Second control bit 7 sets second output level, inverts on overflow.
// - First run bit starts or halts the first counter.
// - Chained: second counts first overflows; its overflow reloads both.
// - Chained: first overflow does not reload, still requests and toggles.
// - PWM: first overflow sets flop, second clears and reloads; clear wins.
// - PWM: first pin is flop, second pin inverted flop; both request.
`default_nettype none

module drt_timer_pair (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timebase_count_clock,
  input wire logic first_event_pin,
  input wire logic second_event_pin,
  output logic first_timer_out,
  output logic second_timer_out,
  output logic first_irq,
  output logic second_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] first_counter_reg;
  logic [7:0] second_counter_reg;
  logic [7:0] first_reload_reg;
  logic [7:0] second_reload_reg;

  // Stored control fields; bits read as one have no flop
  logic [2:0] first_clock_select_reg;
  logic first_run_bit_reg;
  logic first_output_level_reg;
  logic [2:0] second_clock_select_reg;
  logic second_run_bit_reg;
  logic chain_wide_select_reg;
  logic pwm_pair_select_reg;
  logic second_output_level_reg;
  logic pwm_flop_reg;

  logic [7:0] prescale_reg;
  logic [31:0] prdata_reg;

  logic first_timer_out_reg;
  logic second_timer_out_reg;
  logic first_irq_reg;
  logic second_irq_reg;

  // ----------------------------------------------------------------
  // Event pins and count sources
  // ----------------------------------------------------------------
  logic first_evt_rise;
  logic first_evt_fall;
  logic second_evt_rise;
  logic second_evt_fall;

  logic [5:0] div_tick;

  drt_event_sync u_first_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(first_event_pin),
    .rise(first_evt_rise),
    .fall(first_evt_fall)
  );

  drt_event_sync u_second_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(second_event_pin),
    .rise(second_evt_rise),
    .fall(second_evt_fall)
  );

  // Shared prescaler keeps both timers' divided ticks phase aligned
  assign div_tick[0] = timebase_count_clock;
  assign div_tick[1] = timebase_count_clock & ((prescale_reg & drt_pkg::PRE_MASK_DIV2) == drt_pkg::PRE_MASK_DIV2);
  assign div_tick[2] = timebase_count_clock & ((prescale_reg & drt_pkg::PRE_MASK_DIV4) == drt_pkg::PRE_MASK_DIV4);
  assign div_tick[3] = timebase_count_clock & ((prescale_reg & drt_pkg::PRE_MASK_DIV8) == drt_pkg::PRE_MASK_DIV8);
  assign div_tick[4] = timebase_count_clock &
                       ((prescale_reg & drt_pkg::PRE_MASK_DIV32) == drt_pkg::PRE_MASK_DIV32);
  assign div_tick[5] = timebase_count_clock &
                       ((prescale_reg & drt_pkg::PRE_MASK_DIV256) == drt_pkg::PRE_MASK_DIV256);

  // Wraps at 256, so the slowest tap fires once per wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= 8'h00;
    end else if (timebase_count_clock) begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  drt_src_if first_src ();
  drt_src_if second_src ();

  assign first_src.div_tick = div_tick;
  assign first_src.evt_rise = first_evt_rise;
  assign first_src.evt_fall = first_evt_fall;
  assign first_src.sel = first_clock_select_reg;
  assign second_src.div_tick = div_tick;
  assign second_src.evt_rise = second_evt_rise;
  assign second_src.evt_fall = second_evt_fall;
  assign second_src.sel = second_clock_select_reg;

  drt_clock_select u_first_select (
    .src(first_src.select_mp)
  );

  drt_clock_select u_second_select (
    .src(second_src.select_mp)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic hit_first_counter;
  logic hit_second_counter;
  logic hit_first_reload;
  logic hit_second_reload;
  logic hit_first_control;
  logic hit_second_control;

  logic addr_mapped;
  logic access_phase;

  logic wr_en;
  logic [7:0] wbyte;

  assign hit_first_counter = (paddr == drt_pkg::ADDR_FIRST_COUNTER);
  assign hit_second_counter = (paddr == drt_pkg::ADDR_SECOND_COUNTER);
  assign hit_first_reload = (paddr == drt_pkg::ADDR_FIRST_RELOAD);
  assign hit_second_reload = (paddr == drt_pkg::ADDR_SECOND_RELOAD);
  assign hit_first_control = (paddr == drt_pkg::ADDR_FIRST_CONTROL);
  assign hit_second_control = (paddr == drt_pkg::ADDR_SECOND_CONTROL);
  assign addr_mapped = hit_first_counter | hit_second_counter | hit_first_reload |
                       hit_second_reload | hit_first_control | hit_second_control;
  assign access_phase = psel & penable;
  // Only byte lane 0 carries register data; other lanes are dropped
  assign wr_en = access_phase & pwrite & addr_mapped & pstrb[0];
  assign wbyte = pwdata[7:0];

  // Zero wait states: each access ends in its first cycle
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_mapped;

  // ----------------------------------------------------------------
  // Read mux, sampled in the setup cycle so data comes from a flop
  // ----------------------------------------------------------------
  logic [7:0] first_control_view;
  logic [7:0] second_control_view;

  logic [7:0] read_byte;

  assign first_control_view = {first_output_level_reg, drt_pkg::FIRST_CONTROL_ONES,
                               first_run_bit_reg, first_clock_select_reg};
  assign second_control_view = {second_output_level_reg, drt_pkg::SECOND_CONTROL_ONE, pwm_pair_select_reg,
                                chain_wide_select_reg, second_run_bit_reg, second_clock_select_reg};
  assign read_byte = hit_first_counter ? first_counter_reg :
                     hit_second_counter ? second_counter_reg :
                     hit_first_reload ? first_reload_reg :
                     hit_second_reload ? second_reload_reg :
                     hit_first_control ? first_control_view :
                     hit_second_control ? second_control_view : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= {24'h000000, read_byte};
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Counting and overflow
  // ----------------------------------------------------------------
  logic first_tick;
  logic second_tick;

  logic first_ovf;
  logic second_ovf;
  logic mode_linked;

  // Linked modes reload both on a second overflow
  assign mode_linked = chain_wide_select_reg | pwm_pair_select_reg;
  assign first_tick = first_run_bit_reg & first_src.count_pulse;
  // Chained: second counts first overflows; PWM: first run gates both
  assign second_tick = chain_wide_select_reg ? first_ovf :
                       pwm_pair_select_reg ? (first_run_bit_reg & second_src.count_pulse) :
                       (second_run_bit_reg & second_src.count_pulse);
  assign first_ovf = first_tick & (first_counter_reg == drt_pkg::COUNTER_TOP);
  assign second_ovf = second_tick & (second_counter_reg == drt_pkg::COUNTER_TOP);

  // A program write beats reload and count in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_counter_reg <= drt_pkg::COUNTER_RESET;
    end else if (wr_en & hit_first_counter) begin
      first_counter_reg <= wbyte;
    end else if (second_ovf & mode_linked) begin
      first_counter_reg <= first_reload_reg;
    end else if (first_ovf & ~chain_wide_select_reg) begin
      first_counter_reg <= first_reload_reg;
    end else if (first_tick) begin
      first_counter_reg <= first_counter_reg + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_counter_reg <= drt_pkg::COUNTER_RESET;
    end else if (wr_en & hit_second_counter) begin
      second_counter_reg <= wbyte;
    end else if (second_ovf) begin
      second_counter_reg <= second_reload_reg;
    end else if (second_tick) begin
      second_counter_reg <= second_counter_reg + 8'h01;
    end
  end

  // Reset value is not architectural; cleared only for clean simulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_reload_reg <= drt_pkg::COUNTER_RESET;
      second_reload_reg <= drt_pkg::COUNTER_RESET;
    end else begin
      if (wr_en & (hit_first_counter | hit_first_reload)) begin
        first_reload_reg <= wbyte;
      end
      if (wr_en & (hit_second_counter | hit_second_reload)) begin
        second_reload_reg <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // A write in the overflow cycle wins over the toggle of the level bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_clock_select_reg <= drt_pkg::FIRST_CONTROL_RESET[drt_pkg::CTL_SEL_MSB:drt_pkg::CTL_SEL_LSB];
      first_run_bit_reg <= drt_pkg::FIRST_CONTROL_RESET[drt_pkg::CTL_RUN_BIT];
      first_output_level_reg <= drt_pkg::FIRST_CONTROL_RESET[drt_pkg::CTL_OUT_BIT];
    end else if (wr_en & hit_first_control) begin
      first_clock_select_reg <= wbyte[drt_pkg::CTL_SEL_MSB:drt_pkg::CTL_SEL_LSB];
      first_run_bit_reg <= wbyte[drt_pkg::CTL_RUN_BIT];
      first_output_level_reg <= wbyte[drt_pkg::CTL_OUT_BIT];
    end else if (first_ovf) begin
      first_output_level_reg <= ~first_output_level_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_clock_select_reg <= drt_pkg::SECOND_CONTROL_RESET[drt_pkg::CTL_SEL_MSB:drt_pkg::CTL_SEL_LSB];
      second_run_bit_reg <= drt_pkg::SECOND_CONTROL_RESET[drt_pkg::CTL_RUN_BIT];
      chain_wide_select_reg <= drt_pkg::SECOND_CONTROL_RESET[drt_pkg::CTL_WIDE_BIT];
      pwm_pair_select_reg <= drt_pkg::SECOND_CONTROL_RESET[drt_pkg::CTL_PWM_BIT];
      second_output_level_reg <= drt_pkg::SECOND_CONTROL_RESET[drt_pkg::CTL_OUT_BIT];
    end else if (wr_en & hit_second_control) begin
      second_clock_select_reg <= wbyte[drt_pkg::CTL_SEL_MSB:drt_pkg::CTL_SEL_LSB];
      second_run_bit_reg <= wbyte[drt_pkg::CTL_RUN_BIT];
      chain_wide_select_reg <= wbyte[drt_pkg::CTL_WIDE_BIT];
      pwm_pair_select_reg <= wbyte[drt_pkg::CTL_PWM_BIT];
      second_output_level_reg <= wbyte[drt_pkg::CTL_OUT_BIT];
    end else if (second_ovf) begin
      second_output_level_reg <= ~second_output_level_reg;
    end
  end

  // ----------------------------------------------------------------
  // PWM flop, pins and requests
  // ----------------------------------------------------------------
  // Clear is tested first so it wins a tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_flop_reg <= 1'b0;
    end else if (pwm_pair_select_reg & second_ovf) begin
      pwm_flop_reg <= 1'b0;
    end else if (pwm_pair_select_reg & first_ovf) begin
      pwm_flop_reg <= 1'b1;
    end
  end

  logic first_pin_next;
  logic second_pin_next;

  assign first_pin_next = pwm_pair_select_reg ? pwm_flop_reg : first_output_level_reg;
  assign second_pin_next = pwm_pair_select_reg ? ~pwm_flop_reg : second_output_level_reg;

  // Pins lag the level bits by one cycle; requests lag the overflow by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_out_reg <= 1'b0;
      second_timer_out_reg <= 1'b0;
      first_irq_reg <= 1'b0;
      second_irq_reg <= 1'b0;
    end else begin
      first_timer_out_reg <= first_pin_next;
      second_timer_out_reg <= second_pin_next;
      first_irq_reg <= first_ovf;
      second_irq_reg <= second_ovf;
    end
  end

  assign first_timer_out = first_timer_out_reg;
  assign second_timer_out = second_timer_out_reg;
  assign first_irq = first_irq_reg;
  assign second_irq = second_irq_reg;

endmodule

`default_nettype wire

// ==== dv/drt_timer_pair_props.sv ====
// Checker for the timer pair: register readback and output pin relations.
// Assumes it is bound to drt_timer_pair and sees only that module's ports.
`default_nettype none

module drt_timer_pair_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timebase_count_clock,
  input wire logic first_event_pin,
  input wire logic second_event_pin,
  input wire logic first_timer_out,
  input wire logic second_timer_out,
  input wire logic first_irq,
  input wire logic second_irq
);
  // ----------------------------------------
  // Shadow of software-written fields
  // ----------------------------------------
  logic wr, rd, halt;
  logic [7:0] rl1_reg, rl2_reg;
  logic [3:0] c1_reg;
  logic [5:0] c2_reg;
  logic [2:0] cw_reg;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  assign halt = !c1_reg[3] && !c2_reg[3];

  // Control writes may swallow a toggle, so pin checks pause briefly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rl1_reg <= 8'h00;
      rl2_reg <= 8'h00;
      c1_reg <= 4'h0;
      c2_reg <= 6'h00;
      cw_reg <= 3'h0;
    end else begin
      if (wr && (paddr == drt_pkg::ADDR_FIRST_COUNTER || paddr == drt_pkg::ADDR_FIRST_RELOAD))
        rl1_reg <= pwdata[7:0];
      if (wr && (paddr == drt_pkg::ADDR_SECOND_COUNTER || paddr == drt_pkg::ADDR_SECOND_RELOAD))
        rl2_reg <= pwdata[7:0];
      if (wr && paddr == drt_pkg::ADDR_FIRST_CONTROL)
        c1_reg <= pwdata[3:0];
      if (wr && paddr == drt_pkg::ADDR_SECOND_CONTROL)
        c2_reg <= pwdata[5:0];
      if (wr && paddr[11:3] == 9'h036)
        cw_reg <= 3'h4;
      else if (cw_reg != 3'h0)
        cw_reg <= cw_reg - 3'h1;
    end
  end

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_first_ctl_read: assert property (rd && paddr == drt_pkg::ADDR_FIRST_CONTROL |->
    prdata[6:0] == {3'h7, c1_reg}) else $error("first control readback wrong");
  a_second_ctl_read: assert property (rd && paddr == drt_pkg::ADDR_SECOND_CONTROL |->
    prdata[6:0] == {1'b1, c2_reg}) else $error("second control readback wrong");
  a_first_reload_read: assert property (rd && paddr == drt_pkg::ADDR_FIRST_RELOAD |->
    prdata[7:0] == rl1_reg) else $error("first reload readback wrong");
  a_second_reload_read: assert property (rd && paddr == drt_pkg::ADDR_SECOND_RELOAD |->
    prdata[7:0] == rl2_reg) else $error("second reload readback wrong");
  a_pwm_pins_opposed: assert property (c2_reg[5] && $past(c2_reg[5]) && $past(c2_reg[5], 2) |->
    first_timer_out != second_timer_out) else $error("pwm pins not complementary");
  a_first_pin_toggle: assert property (first_irq && cw_reg == 3'h0 && !c2_reg[5] |->
    ##[0:1] $changed(first_timer_out)) else $error("first pin did not toggle");
  a_second_pin_toggle: assert property (second_irq && cw_reg == 3'h0 && !c2_reg[5] |->
    ##[0:1] $changed(second_timer_out)) else $error("second pin did not toggle");
  a_halt_quiet: assert property (halt && $past(halt) && $past(halt, 2) |->
    !first_irq && !second_irq) else $error("request while halted");

  c_first_wrap: cover property (first_irq);
  c_chain_wrap: cover property (c2_reg[4] && second_irq);
  c_pwm_wrap: cover property (c2_reg[5] && second_irq);
endmodule

bind drt_timer_pair drt_timer_pair_props drt_timer_pair_props_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .timebase_count_clock, .first_event_pin, .second_event_pin, .first_timer_out, .second_timer_out,
  .first_irq, .second_irq
);

`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the timer pair: registers, count sources, chain and PWM.
// Assumes a 200 MHz pclk and this module as the only APB master.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic tick = 1'b1;
  logic ev = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, out1, out2, irq1, irq2, err_seen, p1;
  logic [7:0] v;
  int fail_count = 0;
  int check_count = 0;
  int n1 = 0;
  int n2 = 0;
  int hi = 0;
  int c, seed;
  int dv[6] = '{1, 2, 4, 8, 32, 256};

  always #2.5 pclk = ~pclk;

  drt_timer_pair drt_timer_pair_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .timebase_count_clock(tick), .first_event_pin(ev), .second_event_pin(ev),
    .first_timer_out(out1), .second_timer_out(out2), .first_irq(irq1), .second_irq(irq2));

  // Settled values, away from the launching edge
  always @(negedge pclk) begin
    if (irq1 === 1'b1) n1++;
    if (irq2 === 1'b1) n2++;
    if (out1 === 1'b1) hi++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] ctl_exp(input logic second, input logic [7:0] w);
    return second ? {24'h0, w & 8'hC7 | 8'h40} : {24'h0, w & 8'hF7 | 8'h70};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) check(32'(n), 32'h0);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic gap(input int t, output int k);
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while ((t ? irq2 : irq1) !== 1'b1 && k < 5000);
    if (k == 5000) check(32'(k), 32'h0);
  endtask

  task automatic zero();
    @(posedge pclk);
    n1 = 0;
    n2 = 0;
    hi = 0;
  endtask

  task automatic evt(input logic lvl);
    @(posedge pclk);
    ev <= lvl;
    repeat (6) @(posedge pclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(5 * 80000);
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = $urandom(32'hDC2C);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, drt_pkg::ADDR_FIRST_CONTROL, 32'h0);
    check(rd, 32'h70);
    apb(1'b0, drt_pkg::ADDR_SECOND_CONTROL, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, 12'h1B8, 32'h0);
    check(rd, 32'h0);
    check(err_seen, 32'h1);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, {24'h0, v & 8'hF7});
      apb(1'b0, drt_pkg::ADDR_FIRST_CONTROL, 32'h0);
      check(rd, ctl_exp(1'b0, v));
      apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, {24'h0, v & 8'hC7});
      apb(1'b0, drt_pkg::ADDR_SECOND_CONTROL, 32'h0);
      check(rd, ctl_exp(1'b1, v));
      apb(1'b1, drt_pkg::ADDR_FIRST_COUNTER, {24'h0, v});
      apb(1'b0, drt_pkg::ADDR_FIRST_RELOAD, 32'h0);
      check(rd, {24'h0, v});
      apb(1'b1, drt_pkg::ADDR_SECOND_RELOAD, {24'h0, ~v});
      apb(1'b0, drt_pkg::ADDR_SECOND_RELOAD, 32'h0);
      check(rd, {24'h0, ~v});
    end
    pstrb <= 4'h0;
    apb(1'b1, drt_pkg::ADDR_SECOND_RELOAD, 32'h5A);
    pstrb <= 4'hF;
    apb(1'b0, drt_pkg::ADDR_SECOND_RELOAD, 32'h0);
    check(rd, {24'h0, ~v});
    $display("register access done");
    for (int s = 0; s < 6; s++) begin
      v = 8'hF0 | 8'($urandom_range(12));
      apb(1'b1, drt_pkg::ADDR_FIRST_COUNTER, {24'h0, v});
      apb(1'b1, drt_pkg::ADDR_SECOND_COUNTER, {24'h0, v});
      apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'(8 | s));
      apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'(8'h88 | s));
      for (int t = 0; t < 2; t++) begin
        gap(t, c);
        repeat (2) @(negedge pclk);
        p1 = t ? out2 : out1;
        gap(t, c);
        check(32'(c + 2), 32'((256 - v) * dv[s]));
        repeat (2) @(negedge pclk);
        check(t ? out2 : out1, !p1);
      end
    end
    apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'h0);
    apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'h0);
    repeat (4) @(negedge pclk);
    zero();
    repeat (300) @(negedge pclk);
    @(posedge pclk);
    check(32'(n1 + n2), 32'h0);
    $display("prescaled counting done");
    apb(1'b1, drt_pkg::ADDR_FIRST_COUNTER, 32'hFE);
    apb(1'b1, drt_pkg::ADDR_SECOND_COUNTER, 32'hFE);
    for (int s = 6; s < 8; s++) begin
      apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'(8 | s));
      apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'(8 | s));
      zero();
      evt(1'b1);
      evt(1'b0);
      evt(1'b1);
      @(posedge pclk);
      check(32'(n1), 32'(s == 6));
      check(32'(n2), 32'(s == 6));
      apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'h0);
      apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'h0);
      evt(1'b0);
    end
    $display("event counting done");
    apb(1'b1, drt_pkg::ADDR_FIRST_COUNTER, 32'hFE);
    apb(1'b1, drt_pkg::ADDR_SECOND_COUNTER, 32'hFE);
    apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'h17);
    apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'h08);
    gap(1, c);
    zero();
    gap(1, c);
    @(posedge pclk);
    check(32'(c), 32'd258);
    check(32'(n1), 32'd2);
    check(32'(n2), 32'd1);
    $display("chained mode done");
    apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'h0);
    apb(1'b1, drt_pkg::ADDR_FIRST_COUNTER, 32'hFE);
    apb(1'b1, drt_pkg::ADDR_FIRST_RELOAD, 32'hFC);
    apb(1'b1, drt_pkg::ADDR_SECOND_COUNTER, 32'hF8);
    apb(1'b1, drt_pkg::ADDR_SECOND_CONTROL, 32'h20);
    apb(1'b1, drt_pkg::ADDR_FIRST_CONTROL, 32'h08);
    gap(1, c);
    zero();
    repeat (80) @(negedge pclk);
    @(posedge pclk);
    check(32'(hi), 32'd40);
    check(32'(n1), 32'd20);
    check(32'(n2), 32'd10);
    $display("pwm mode done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
